/* shared/wdt_map.svh */
// register map, field positions and timing constants of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define RCS_DATA_ADDR 8'h54
`define IO_SPACE_DELTA 8'h20
`define WCS_DATA_ADDR 8'h60
`define RCS_RESET 8'h00
`define WCS_RESET 8'h00
`define BIT_WD_RESET_CAUSE_FLAG 3
`define BIT_BROWNOUT_CAUSE_FLAG 2
`define BIT_PIN_RESET_CAUSE_FLAG 1
`define BIT_POWERON_CAUSE_FLAG 0
`define BIT_IF 7
`define BIT_IE 6
`define BIT_P3 5
`define BIT_CE 4
`define BIT_RE 3
`define CE_WINDOW_CYC 3'h4
`define TICK_BASE_LOG2 11
`define PERIOD_MAX_CODE 4'h9
`define SYS_CLK_HZ 25000000
`define OSC_HZ 128000
`define OSC_DIV_CYC ((`SYS_CLK_HZ) / (`OSC_HZ))
`endif

/* shared/wdt_pkg.sv */
// types shared by the watchdog modules
package wdt_pkg;
	typedef enum logic [1:0] {
		MODE_STOPPED,
		MODE_IRQ,
		MODE_RESET,
		MODE_IRQ_RESET
	} wd_mode_t;
endpackage

/* shared/wdt_tick_if.sv */
// timer interface between the control logic and the counter
`timescale 1ns/100ps
interface wdt_tick_if;
	logic run;
	logic restart;
	logic [3:0] period;
	logic timeout;
	modport ctrl (output run, output restart, output period, input timeout);
	modport cnt (input run, input restart, input period, output timeout);
endinterface

/* hdl/wdt_counter.sv */
// watchdog oscillator divider and period counter
`timescale 1ns/100ps
`include "wdt_map.svh"
module wdt_counter
	import wdt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	wdt_tick_if.cnt tk
);
	logic [9:0] div_r;
	logic [20:0] cnt_r;
	logic osc_tick;
	logic [20:0] limit;
	// one-cycle pulse at the slow oscillator rate
	assign osc_tick = (div_r == 10'(`OSC_DIV_CYC - 1));
	assign limit = 21'(21'h1 << (`TICK_BASE_LOG2 + 32'(tk.period))) - 21'h1;
	assign tk.timeout = tk.run && osc_tick && (cnt_r >= limit);
	// divider free-runs so restart timing matches a separate oscillator
	always_ff @(posedge mclk) begin
		if (rst || osc_tick)
			div_r <= 10'h0;
		else
			div_r <= div_r + 10'h1;
	end
	// counter clears on restart, stop or expiry
	always_ff @(posedge mclk) begin
		if (rst || tk.restart || !tk.run || tk.timeout)
			cnt_r <= 21'h0;
		else if (osc_tick)
			cnt_r <= cnt_r + 21'h1;
	end
endmodule // wdt_counter

/* hdl/wdt_top.sv */
// watchdog timer with reset cause status register
// Notes on behaviour
// - watchdog reset sets cause bit 3
// - brown-out reset sets cause bit 2
// - pin reset sets cause bit 1
// - power-on sets bit 0; only write clears
// - status register also at io address 0x34
// - timeout in interrupt mode sets bit 7
// - vector execution or writing one clears flag
// - interrupt needs flag, enable, global enable
// - enable only: interrupt mode
// - both enables: interrupt then reset mode
// - vector clears enable and flag there
// - unserviced flag at next timeout resets
// - programmed fuse forces system reset mode
// - reset-enable clear, period change need window
// - change enable self-clears after four cycles
// - reset enable reads set while cause set
// - period code selects 2048 doubling cycles
// - counter runs on separate 128 kHz rate
// - restart instruction zeroes the counter
// - reset mode resets on timeout
`timescale 1ns/100ps
`include "wdt_map.svh"
module wdt_top
	import wdt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic por_event,
	input wire logic pin_reset_event,
	input wire logic brownout_event,
	input wire logic wd_always_on_fuse,
	input wire logic wd_restart,
	input wire logic irq_vector_ack,
	input wire logic global_irq_enable,
	input wire logic [7:0] bus_addr,
	input wire logic bus_io_space,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic wd_irq_req,
	output logic wd_sys_reset
);
	logic [3:0] cause_r;
	logic wd_irq_flag_r, wd_irq_enable_r, wd_reset_enable_r;
	logic wd_change_enable_r;
	logic [2:0] ce_cnt_r;
	logic [3:0] wd_period_select_r;
	logic [7:0] rdata_r;
	logic sysrst_r;
	logic fuse_s1_r, fuse_s2_r, por_s1_r, por_s2_r;
	logic pin_s1_r, pin_s2_r, bor_s1_r, bor_s2_r;
	logic [7:0] eff_addr;
	logic sel_rcs, sel_wcs, wr_rcs, wr_wcs, fuse_on, re_eff;
	logic win_open, timeout, to_irq, to_reset;
	logic [3:0] period_wr;
	logic [3:0] cause_nxt;
	wd_mode_t mode;
	wdt_tick_if tk ();

	// asynchronous event pins pass a two-stage synchroniser
	always_ff @(posedge mclk) begin
		fuse_s1_r <= wd_always_on_fuse;
		fuse_s2_r <= fuse_s1_r;
		por_s1_r <= por_event;
		por_s2_r <= por_s1_r;
		pin_s1_r <= pin_reset_event;
		pin_s2_r <= pin_s1_r;
		bor_s1_r <= brownout_event;
		bor_s2_r <= bor_s1_r;
	end

	// io-space accesses sit 0x20 below the data-space address
	assign eff_addr = bus_io_space ? bus_addr + `IO_SPACE_DELTA : bus_addr;
	assign sel_rcs = (eff_addr == `RCS_DATA_ADDR);
	assign sel_wcs = (eff_addr == `WCS_DATA_ADDR);
	assign wr_rcs = bus_wr && sel_rcs;
	assign wr_wcs = bus_wr && sel_wcs;

	// mode decode from fuse and enables
	assign fuse_on = !fuse_s2_r;
	assign re_eff = wd_reset_enable_r || cause_r[`BIT_WD_RESET_CAUSE_FLAG];
	always_comb begin
		if (fuse_on)
			mode = MODE_RESET;
		else if (re_eff && wd_irq_enable_r)
			mode = MODE_IRQ_RESET;
		else if (re_eff)
			mode = MODE_RESET;
		else if (wd_irq_enable_r)
			mode = MODE_IRQ;
		else
			mode = MODE_STOPPED;
	end

	assign tk.run = (mode != MODE_STOPPED);
	assign tk.restart = wd_restart;
	assign tk.period = wd_period_select_r;
	assign timeout = tk.timeout;
	// pending unserviced flag in escalation mode turns timeout into reset
	assign to_irq = timeout && (mode == MODE_IRQ ||
		(mode == MODE_IRQ_RESET && !wd_irq_flag_r));
	assign to_reset = timeout && (mode == MODE_RESET ||
		(mode == MODE_IRQ_RESET && wd_irq_flag_r));
	assign win_open = wd_change_enable_r;
	// out-of-range codes are refused and the old period kept
	assign period_wr = {bus_wdata[`BIT_P3], bus_wdata[2:0]};

	wdt_counter u_cnt (
		.mclk(mclk),
		.rst(rst),
		.tk(tk)
	);

	// reset cause bits; hardware set wins over software clear
	always_comb begin
		cause_nxt = cause_r;
		if (wr_rcs)
			cause_nxt = cause_r & bus_wdata[3:0];
		if (por_s2_r)
			cause_nxt = 4'h1;
		else begin
			if (sysrst_r)
				cause_nxt[`BIT_WD_RESET_CAUSE_FLAG] = 1'b1;
			if (bor_s2_r)
				cause_nxt[`BIT_BROWNOUT_CAUSE_FLAG] = 1'b1;
			if (pin_s2_r)
				cause_nxt[`BIT_PIN_RESET_CAUSE_FLAG] = 1'b1;
		end
	end
	// cause register survives the system reset on purpose
	always_ff @(posedge mclk) begin
		cause_r <= cause_nxt;
	end

	// interrupt flag: timeout set wins over clears
	always_ff @(posedge mclk) begin
		if (rst)
			wd_irq_flag_r <= 1'b0;
		else if (to_irq)
			wd_irq_flag_r <= 1'b1;
		else if (irq_vector_ack || (wr_wcs && bus_wdata[`BIT_IF]))
			wd_irq_flag_r <= 1'b0;
	end

	// interrupt enable; vector clears it in escalation mode
	always_ff @(posedge mclk) begin
		if (rst || fuse_on)
			wd_irq_enable_r <= 1'b0;
		else if (irq_vector_ack && mode == MODE_IRQ_RESET)
			wd_irq_enable_r <= 1'b0;
		else if (wr_wcs)
			wd_irq_enable_r <= bus_wdata[`BIT_IE];
	end

	// reset enable may be cleared only inside the window
	always_ff @(posedge mclk) begin
		if (rst)
			wd_reset_enable_r <= 1'b0;
		else if (wr_wcs && (bus_wdata[`BIT_RE] || win_open))
			wd_reset_enable_r <= bus_wdata[`BIT_RE];
	end

	// period select changes only inside the window
	always_ff @(posedge mclk) begin
		if (rst)
			wd_period_select_r <= 4'h0;
		else if (wr_wcs && win_open && period_wr <= `PERIOD_MAX_CODE)
			wd_period_select_r <= period_wr;
	end

	// change window opens on a write of both bits, closes after 4 cycles
	always_ff @(posedge mclk) begin
		if (rst) begin
			wd_change_enable_r <= 1'b0;
			ce_cnt_r <= 3'h0;
		end else if (wr_wcs && bus_wdata[`BIT_CE] && bus_wdata[`BIT_RE]) begin
			wd_change_enable_r <= 1'b1;
			ce_cnt_r <= 3'h0;
		end else if (wr_wcs || ce_cnt_r == `CE_WINDOW_CYC - 3'h1) begin
			wd_change_enable_r <= 1'b0;
			ce_cnt_r <= 3'h0;
		end else if (wd_change_enable_r)
			ce_cnt_r <= ce_cnt_r + 3'h1;
	end

	// one-cycle system reset pulse on timeout
	always_ff @(posedge mclk) begin
		if (rst)
			sysrst_r <= 1'b0;
		else
			sysrst_r <= to_reset;
	end
	assign wd_sys_reset = sysrst_r;
	assign wd_irq_req = wd_irq_flag_r && wd_irq_enable_r &&
		global_irq_enable;

	// registered read data, zero for unmapped addresses
	always_ff @(posedge mclk) begin
		if (rst)
			rdata_r <= 8'h00;
		else if (bus_rd && sel_rcs)
			rdata_r <= {4'h0, cause_r};
		else if (bus_rd && sel_wcs)
			rdata_r <= {wd_irq_flag_r, wd_irq_enable_r,
				wd_period_select_r[3], wd_change_enable_r,
				re_eff || fuse_on, wd_period_select_r[2:0]};
		else
			rdata_r <= 8'h00;
	end
	assign bus_rdata = rdata_r;

	// change window closes by itself four cycles after it opens
	property ce_close_p;
		@(posedge mclk) disable iff (rst)
		($rose(wd_change_enable_r) && !bus_wr)[*1] ##0 (!bus_wr)[*4]
			|=> !wd_change_enable_r;
	endproperty
	ce_closes_a: assert property (ce_close_p)
		else $error("change enable stayed open too long");

	// the timed change is two steps: an opening write, then the settings
	sequence ce_open_s;
		wr_wcs && bus_wdata[`BIT_CE] && bus_wdata[`BIT_RE];
	endsequence
	sequence ce_apply_s;
		wr_wcs && win_open && !bus_wdata[`BIT_CE];
	endsequence
	ce_opens_a: assert property (@(posedge mclk) disable iff (rst)
		ce_open_s |=> wd_change_enable_r)
		else $error("change enable did not open");
	re_clear_a: assert property (@(posedge mclk) disable iff (rst)
		ce_apply_s ##0 !bus_wdata[`BIT_RE] |=> !wd_reset_enable_r)
		else $error("reset enable not cleared in window");

	// cause flags; power-on has priority over every other source
	wd_reset_cause_flag_sets_a: assert property (@(posedge mclk) disable iff (rst)
		sysrst_r && !por_s2_r |=> cause_r[`BIT_WD_RESET_CAUSE_FLAG])
		else $error("watchdog cause not set");
	bor_sets_a: assert property (@(posedge mclk) disable iff (rst)
		bor_s2_r && !por_s2_r |=> cause_r[`BIT_BROWNOUT_CAUSE_FLAG])
		else $error("brownout cause not set");
	pin_sets_a: assert property (@(posedge mclk) disable iff (rst)
		pin_s2_r && !por_s2_r |=> cause_r[`BIT_PIN_RESET_CAUSE_FLAG])
		else $error("pin cause not set");
	por_sets_a: assert property (@(posedge mclk)
		por_s2_r |=> cause_r == 4'h1)
		else $error("power-on cause not set");
	io_decode_a: assert property (@(posedge mclk) disable iff (rst)
		bus_io_space && bus_addr == (`RCS_DATA_ADDR - `IO_SPACE_DELTA)
			|-> sel_rcs)
		else $error("io alias of cause register not decoded");

	// interrupt flag, enable and request
	irq_req_a: assert property (@(posedge mclk) disable iff (rst)
		wd_irq_req |-> wd_irq_flag_r && wd_irq_enable_r)
		else $error("interrupt request without cause");
	irq_on_a: assert property (@(posedge mclk) disable iff (rst)
		wd_irq_flag_r && wd_irq_enable_r && global_irq_enable
			|-> wd_irq_req)
		else $error("interrupt request missing");
	irq_flag_a: assert property (@(posedge mclk) disable iff (rst)
		timeout && mode == MODE_IRQ |=> wd_irq_flag_r)
		else $error("interrupt flag not set on timeout");
	vec_clear_a: assert property (@(posedge mclk) disable iff (rst)
		irq_vector_ack && !timeout |=> !wd_irq_flag_r)
		else $error("vector did not clear interrupt flag");
	esc_vec_a: assert property (@(posedge mclk) disable iff (rst)
		irq_vector_ack && !timeout && mode == MODE_IRQ_RESET
			|=> !wd_irq_enable_r && !wd_irq_flag_r)
		else $error("vector did not drop to reset mode");

	// timeout actions and the modes that select them
	esc_reset_a: assert property (@(posedge mclk) disable iff (rst)
		timeout && mode == MODE_IRQ_RESET && wd_irq_flag_r
			|=> wd_sys_reset ##1 !wd_sys_reset)
		else $error("escalation reset missing");
	rst_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		wd_sys_reset |=> !wd_sys_reset)
		else $error("system reset longer than one cycle");
	fuse_mode_a: assert property (@(posedge mclk) disable iff (rst)
		fuse_on |-> mode == MODE_RESET)
		else $error("fuse did not force reset mode");
	fuse_ie_a: assert property (@(posedge mclk) disable iff (rst)
		fuse_on |=> !wd_irq_enable_r)
		else $error("fuse left interrupt enable set");
	re_hold_a: assert property (@(posedge mclk) disable iff (rst)
		wd_reset_enable_r && !win_open |=> wd_reset_enable_r)
		else $error("reset enable cleared outside window");
	per_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!(wr_wcs && win_open) |=> $stable(wd_period_select_r))
		else $error("period changed outside window");
	per_range_a: assert property (@(posedge mclk) disable iff (rst)
		wd_period_select_r <= `PERIOD_MAX_CODE)
		else $error("period code out of range");
	re_read_a: assert property (@(posedge mclk) disable iff (rst)
		bus_rd && sel_wcs && cause_r[`BIT_WD_RESET_CAUSE_FLAG] |=> bus_rdata[`BIT_RE])
		else $error("reset enable not forced by cause");
	stop_a: assert property (@(posedge mclk) disable iff (rst)
		mode == MODE_STOPPED |=> !wd_sys_reset)
		else $error("stopped watchdog acted");
	stop_tick_a: assert property (@(posedge mclk) disable iff (rst)
		!tk.run |-> !timeout)
		else $error("stopped watchdog timed out");
endmodule // wdt_top

/* dv/testbench.sv */
// self-checking bench for the watchdog register and cause logic
`timescale 1ns/100ps
`include "wdt_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import wdt_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic por_event = 1'b1;
	logic pin_reset_event = 1'b0;
	logic brownout_event = 1'b0;
	logic fuse = 1'b1;
	logic wd_restart = 1'b0;
	logic irq_vector_ack = 1'b0;
	logic global_irq_enable = 1'b1;
	logic [7:0] bus_addr = 8'h00;
	logic bus_io_space = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata;
	logic wd_irq_req;
	logic wd_sys_reset;
	int num_errors = 0;
	int samples_checked = 0;

	// 40 ns period
	always #20 mclk = ~mclk;

	wdt_top dut_u (.mclk(mclk), .rst(rst), .por_event(por_event),
		.pin_reset_event(pin_reset_event),
		.brownout_event(brownout_event), .wd_always_on_fuse(fuse),
		.wd_restart(wd_restart), .irq_vector_ack(irq_vector_ack),
		.global_irq_enable(global_irq_enable), .bus_addr(bus_addr),
		.bus_io_space(bus_io_space), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.wd_irq_req(wd_irq_req), .wd_sys_reset(wd_sys_reset));

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// one-cycle write strobe; a clock gap between accesses keeps strobes clean
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		idle(1);
		bus_addr = a;
		bus_io_space = 1'b0;
		bus_wdata = d;
		bus_wr = 1'b1;
		idle(1);
		bus_wr = 1'b0;
	endtask

	// read data is registered, so it is sampled just after the taking edge
	task automatic rd(input logic [7:0] a, input logic io,
		output logic [7:0] q);
		idle(1);
		bus_addr = a;
		bus_io_space = io;
		bus_rd = 1'b1;
		idle(1);
		bus_rd = 1'b0;
		q = bus_rdata;
	endtask

	// events are asynchronous and pass two sync flops before they land
	task automatic pulse(ref logic s);
		s = 1'b1;
		idle(3);
		s = 1'b0;
		idle(4);
	endtask

	task automatic end_test(input string name);
		$display("test %s done, errors so far %0d", name, num_errors);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// whole sequence takes about a hundred cycles; allow ample margin
	initial begin
		#120000;
		num_errors++;
		stop_test();
	end

	initial begin : main
		logic [7:0] q;
		idle(5);
		rst = 1'b0;
		por_event = 1'b0;
		idle(4);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, `WCS_RESET)
		rd(`RCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h01)
		rd(`RCS_DATA_ADDR - `IO_SPACE_DELTA, 1'b1, q);
		`CHK(q, 8'h01)
		end_test("reset");

		// causes accumulate until power-on wipes them
		pulse(pin_reset_event);
		rd(`RCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h03)
		pulse(brownout_event);
		rd(`RCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h07)
		pulse(por_event);
		rd(`RCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h01)
		wr(`RCS_DATA_ADDR, 8'h00);
		rd(`RCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h00)
		end_test("causes");

		// unguarded writes may set reset enable but not clear it
		wr(`WCS_DATA_ADDR, 8'h08);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h08)
		wr(`WCS_DATA_ADDR, 8'h00);
		wr(`WCS_DATA_ADDR, 8'h0d);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h08)
		wd_restart = 1'b1;
		idle(1);
		wd_restart = 1'b0;
		wr(`WCS_DATA_ADDR, 8'h18);
		wr(`WCS_DATA_ADDR, 8'h05);
		rd(`WCS_DATA_ADDR - `IO_SPACE_DELTA, 1'b1, q);
		`CHK(q, 8'h05)
		end_test("window");

		// a window left unused closes by itself
		wr(`WCS_DATA_ADDR, 8'h1d);
		idle(8);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h0d)
		wr(`WCS_DATA_ADDR, 8'h01);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h0d)
		end_test("expiry");

		// enable without a pending flag gives no request
		wr(`WCS_DATA_ADDR, 8'h4d);
		wd_restart = 1'b1;
		idle(1);
		wd_restart = 1'b0;
		`CHK(wd_irq_req, 1'b0)
		wr(`WCS_DATA_ADDR, 8'hcd);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h4d)
		// vector in escalation mode drops the enable
		irq_vector_ack = 1'b1;
		idle(1);
		irq_vector_ack = 1'b0;
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h0d)
		wr(`WCS_DATA_ADDR, 8'h4d);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h4d)
		rd(`WCS_DATA_ADDR + 8'h01, 1'b0, q);
		`CHK(q, 8'h00)
		end_test("irq");

		// programmed fuse forces reset mode and drops the enable
		fuse = 1'b0;
		idle(4);
		rd(`WCS_DATA_ADDR, 1'b0, q);
		`CHK(q, 8'h0d)
		fuse = 1'b1;
		`CHK(wd_sys_reset, 1'b0)
		end_test("fuse");
		stop_test();
	end
endmodule // testbench
